// file: rtl/rrtc_bank.sv
// radio end state, antenna termination and correction configuration bank
//
// What this block does
// - after-transmit selector picks next radio state
// - bad packet without abort stays receiving
// - bad packet with abort goes idle/sleep
// - code zero disables termination; 111 reserved
// - carrier sense single or continuous antenna switching
// - preamble quality single or continuous switching
// - one bit enables ramping and shaping, reset one
// - target level resets all ones; low special
// - two ramp steps in sixteenths
// - ramp length selects ramp and shape times
// - keying filter scale and cut-off multiplier
// - low level is target minus depth, zero when depth exceeds target
// - frame length zero means 256 bytes
// - mixer selects zero or divided IF
// - frequency correction placement and loop gain
// - synthesizer correction limit quarter or eighth
// - raw stream and gain form loop selector
// - timing offset limit, wide needs carrier gate
// - block integration window before sync
// - proportional scale factor when limit nonzero
// - after-receive selector picks next state
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`default_nettype none
module rrtc_bank
  import rrtc_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  input  wire logic              i_clk_en,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // radio events, one-cycle pulses from the modem
  input  wire logic              i_tx_start,
  input  wire logic              i_rx_start,
  input  wire logic              i_tx_done,
  input  wire logic              i_rx_good,
  input  wire logic              i_rx_bad,
  input  wire logic              i_rx_timeout,
  input  wire logic              i_sync_det,
  input  wire logic              i_cs_eval,
  input  wire logic              i_cs_ok,
  input  wire logic              i_pq_eval,
  input  wire logic              i_pq_ok,
  // radio control
  output rrtc_state_t            o_radio_state,
  output logic                   o_antenna,
  output logic                   o_rx_terminated,
  output rrtc_cfg_t              o_cfg
);
  logic [7:0]  rf [NREG];
  rrtc_end_t   end_r;
  rrtc_ramp_t  ramp_r;
  rrtc_shape_t shp_r;
  rrtc_ask_t   ask_r;
  rrtc_mix_t   mix_r;
  rrtc_foc_t   foc_r;
  rrtc_toc_t   toc_r;
  rrtc_misc_t  misc_r;
  logic        switched;
  logic        settled;
  logic        sync_seen;
  logic [3:0]  idx;
  logic        hit;
  logic        acc;
  logic [7:0]  rd_byte;
  rrtc_cfg_t   next_cfg;

  assign end_r  = rrtc_end_t'(rf[IX_END]);
  assign ramp_r = rrtc_ramp_t'(rf[IX_RAMP]);
  assign shp_r  = rrtc_shape_t'(rf[IX_SHP]);
  assign ask_r  = rrtc_ask_t'(rf[IX_ASK]);
  assign mix_r  = rrtc_mix_t'(rf[IX_MIX]);
  assign foc_r  = rrtc_foc_t'(rf[IX_FOC]);
  assign toc_r  = rrtc_toc_t'(rf[IX_TOC]);
  assign misc_r = rrtc_misc_t'(rf[IX_MISC]);

  function automatic rrtc_state_t sel_state(input logic [1:0] s);
    unique case (s)
      ST_IDLE:  sel_state = RRTC_IDLE;
      ST_SYNTH: sel_state = RRTC_SYNTH;
      ST_TX:    sel_state = RRTC_TX;
      ST_RX:    sel_state = RRTC_RX;
    endcase
  endfunction

  // shift of a power of two: value 1 << (base + s) encoded as base + s
  function automatic logic [3:0] pow2(input logic [1:0] s, input logic [3:0] base);
    pow2 = base + {2'b00, s};
  endfunction

  // apb decode: aligned words only
  assign idx = i_paddr[5:2];
  assign hit = (i_paddr[1:0] == 2'b00) && (i_paddr[ADDR_W-1:6] == '0)
               && (idx <= IX_STAT);
  assign acc = i_psel && i_penable && o_pready;

  always_comb begin
    if (idx == IX_STAT) begin
      rd_byte = {o_radio_state == RRTC_RX, switched, settled, o_radio_state};
    end else if (hit) begin
      rd_byte = rf[idx];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // one wait state keeps read data and pready straight from flops
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_prdata  <= {24'h00_0000, rd_byte};
      o_pslverr <= i_psel && i_penable && !o_pready && !hit;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < NREG; k++) begin
        rf[k] <= REG_RST[k];
      end
    end else if (i_clk_en && acc && i_pwrite && hit && idx < IX_STAT) begin
      rf[idx] <= i_pwdata[7:0] & REG_MASK[idx];
    end
  end

  // radio end state machine with termination and antenna switching
  logic eval;
  logic ok;
  logic term;
  logic pq_mode;
  assign pq_mode = end_r.rx_term_antenna_sel[2];
  assign eval = !settled && (pq_mode ? i_pq_eval : i_cs_eval);
  assign ok   = pq_mode ? i_pq_ok : i_cs_ok;

  always_comb begin
    unique case (end_r.rx_term_antenna_sel)
      TERM_CS, TERM_PQ: term = eval && !ok;
      DIV_CS1, DIV_PQ1: term = eval && !ok && switched;
      default:          term = 1'b0; // off, continuous and reserved codes
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_radio_state   <= RRTC_IDLE;
      o_rx_terminated <= 1'b0;
    end else if (i_clk_en) begin
      o_rx_terminated <= 1'b0;
      unique case (o_radio_state)
        RRTC_TX: begin
          if (i_tx_done) begin
            o_radio_state <= sel_state(end_r.after_tx_state_sel);
          end
        end
        RRTC_RX: begin
          if (i_rx_bad) begin
            if (end_r.bad_packet_abort_en) begin
              o_radio_state <= misc_r.wor_used ? RRTC_SLEEP : RRTC_IDLE;
            end // else stays receiving
          end else if (i_rx_good) begin
            o_radio_state <= sel_state(misc_r.after_rx_state_sel);
          end else if (term || i_rx_timeout) begin
            o_radio_state   <= RRTC_IDLE;
            o_rx_terminated <= 1'b1;
          end else if (i_tx_start) begin
            o_radio_state <= RRTC_TX;
          end
        end
        default: begin
          if (i_tx_start) begin
            o_radio_state <= RRTC_TX;
          end else if (i_rx_start) begin
            o_radio_state <= RRTC_RX;
          end
        end
      endcase
    end
  end

  // antenna bookkeeping restarts on every entry to receive
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_antenna <= 1'b0;
      switched  <= 1'b0;
      settled   <= 1'b0;
    end else if (i_clk_en) begin
      if (o_radio_state != RRTC_RX) begin
        switched <= 1'b0;
        settled  <= 1'b0;
      end else if (eval && ok) begin
        settled <= 1'b1;
      end else if (eval) begin
        unique case (end_r.rx_term_antenna_sel)
          DIV_CS1, DIV_PQ1: begin
            if (!switched) begin
              o_antenna <= !o_antenna;
              switched  <= 1'b1;
            end
          end
          DIV_CSN, DIV_PQN: begin
            o_antenna <= !o_antenna;
            switched  <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // sync detection moves synthesizer correction back after the filter
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sync_seen <= 1'b0;
    end else if (i_clk_en) begin
      if (o_radio_state != RRTC_RX) begin
        sync_seen <= 1'b0;
      end else if (i_sync_det) begin
        sync_seen <= 1'b1;
      end
    end
  end

  // derived settings, registered so every output is a flop
  always_comb begin
    next_cfg = '0;
    next_cfg.ramp_en     = ramp_r.amp_ramp_shape_en;
    next_cfg.amp_special = ramp_r.amp_target_level < AMP_LIN_MIN;
    next_cfg.first_step_16ths  = {1'b0, shp_r.first_step_level};
    next_cfg.second_step_16ths = HALF_16THS | {1'b0, shp_r.second_step_level};
    next_cfg.ramp_8ths   = 6'(3) << (shp_r.ramp_length_sel == 2'b00 ? 3'd0
                           : 3'({1'b0, shp_r.ramp_length_sel} + 3'd1));
    next_cfg.shape_32nds = 4'(1) << shp_r.ramp_length_sel;
    unique case (ask_r.amplitude_filter_bw)
      2'b00: next_cfg.ask_scale_pct = 5'd28;
      2'b01: next_cfg.ask_scale_pct = 5'd18;
      2'b10: next_cfg.ask_scale_pct = 5'd15;
      2'b11: next_cfg.ask_scale_pct = 5'd14;
    endcase
    next_cfg.ask_mult = misc_r.rx_limit_cfg ? 4'd8 : 4'd4;
    if (ramp_r.amp_target_level > ask_r.amplitude_depth) begin
      next_cfg.amp_low_level = ramp_r.amp_target_level - ask_r.amplitude_depth;
    end
    next_cfg.keyed_off    = next_cfg.amp_low_level == 6'h00;
    next_cfg.frame_bytes  = rf[IX_LEN] == 8'h00 ? LEN_MAX : {1'b0, rf[IX_LEN]};
    next_cfg.frame_is_max = !misc_r.fixed_len_mode;
    next_cfg.if_zero      = mix_r.mixer_if_sel[1:0] == 2'b00;
    next_cfg.if_positive  = mix_r.mixer_if_sel[2];
    unique case (mix_r.mixer_if_sel[1:0])
      2'b01:   next_cfg.if_div = 4'd4;
      2'b10:   next_cfg.if_div = 4'd6;
      2'b11:   next_cfg.if_div = 4'd8;
      default: next_cfg.if_div = 4'd0;
    endcase
    next_cfg.foc_active   = foc_r.freq_corr_en;
    next_cfg.foc_in_synth = foc_r.freq_corr_en && foc_r.freq_corr_cfg != 2'b00
                            && !sync_seen;
    if (foc_r.freq_corr_cfg != 2'b00) begin
      next_cfg.foc_synth_shift = pow2(foc_r.freq_corr_cfg - 2'd1, 4'd7);
      next_cfg.freq_corr_limit_div   = foc_r.freq_corr_limit ? 4'd8 : 4'd4;
    end
    if (misc_r.raw_stream_en) begin
      next_cfg.foc_track_shift = pow2(foc_r.freq_corr_gain, 4'd7);
    end else if (foc_r.freq_corr_gain == 2'b00) begin
      next_cfg.foc_stop_after_sync = 1'b1;
    end else begin
      next_cfg.foc_track_shift = pow2(foc_r.freq_corr_gain - 2'd1, 4'd5);
    end
    next_cfg.timing_offset_correction_config_err = toc_r.timing_corr_limit == 2'b10
      || (toc_r.timing_corr_limit == TOC_WIDE && !misc_r.carrier_gate);
    next_cfg.toc_block_mode = toc_r.timing_corr_limit == 2'b00;
    if (next_cfg.toc_block_mode) begin
      if (!toc_r.timing_presync_window[2] || !toc_r.timing_presync_window[1]) begin
        next_cfg.toc_window_syms = 9'(8) << toc_r.timing_presync_window;
      end
    end else begin
      unique case (toc_r.timing_presync_window)
        3'b000:  next_cfg.toc_prop_16ths = 4'd8;
        3'b001:  next_cfg.toc_prop_16ths = 4'd6;
        3'b010:  next_cfg.toc_prop_16ths = 4'd2;
        default: next_cfg.toc_prop_16ths = 4'd1;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_cfg <= '0;
    end else if (i_clk_en) begin
      o_cfg <= next_cfg;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);

  tx_end_a: assert property (o_radio_state == RRTC_TX && i_tx_done && i_clk_en
    && end_r.after_tx_state_sel == ST_RX |=> o_radio_state == RRTC_RX)
    else $error("after-transmit state not taken");
  bad_stay_a: assert property (o_radio_state == RRTC_RX && i_rx_bad && i_clk_en
    && !end_r.bad_packet_abort_en |=> o_radio_state == RRTC_RX)
    else $error("bad packet left receive");
  bad_abort_a: assert property (o_radio_state == RRTC_RX && i_rx_bad && i_clk_en
    && end_r.bad_packet_abort_en && !misc_r.wor_used |=> o_radio_state == RRTC_IDLE)
    else $error("bad packet abort missed idle");
  term_off_a: assert property (o_rx_terminated |-> $past(i_rx_timeout)
    || $past(end_r.rx_term_antenna_sel) != TERM_OFF)
    else $error("termination while disabled");
  single_sw_a: assert property (o_radio_state == RRTC_RX && i_clk_en && !i_rx_bad
    && !i_rx_good && !i_rx_timeout && end_r.rx_term_antenna_sel == DIV_CS1
    && !i_tx_start && i_cs_eval && !i_cs_ok && !settled && !switched
    |=> o_antenna != $past(o_antenna) && o_radio_state == RRTC_RX)
    else $error("single switch did not flip antenna");
  low_level_a: assert property (i_clk_en && ramp_r.amp_target_level
    == ask_r.amplitude_depth |=> o_cfg.keyed_off)
    else $error("zero difference not keyed off");
  frame_len_a: assert property ($past(i_clk_en) && !$past(i_reset)
    |-> o_cfg.frame_bytes != 9'h000)
    else $error("frame length reads zero");
  toc_gate_a: assert property (i_clk_en && toc_r.timing_corr_limit == TOC_WIDE
    && !misc_r.carrier_gate |=> o_cfg.timing_offset_correction_config_err)
    else $error("wide timing limit without gate not flagged");
  toc_window_a: assert property ($past(i_clk_en) && !$past(i_reset)
    && !o_cfg.toc_block_mode |-> o_cfg.toc_window_syms == 9'h000
    && o_cfg.toc_prop_16ths != 4'h0)
    else $error("timing field decoded in wrong mode");
endmodule // rrtc_bank
`default_nettype wire

// file: rtl/rrtc_pkg.sv
// shared types and constants for the radio end and correction register bank
`default_nettype none
package rrtc_pkg;
  localparam int ADDR_W = 8;
  localparam int NREG   = 9;
  // register word indices, byte address is four times the index
  localparam logic [3:0] IX_END  = 4'h0;
  localparam logic [3:0] IX_RAMP = 4'h1;
  localparam logic [3:0] IX_SHP  = 4'h2;
  localparam logic [3:0] IX_ASK  = 4'h3;
  localparam logic [3:0] IX_LEN  = 4'h4;
  localparam logic [3:0] IX_MIX  = 4'h5;
  localparam logic [3:0] IX_FOC  = 4'h6;
  localparam logic [3:0] IX_TOC  = 4'h7;
  localparam logic [3:0] IX_MISC = 4'h8;
  localparam logic [3:0] IX_STAT = 4'h9;
  localparam logic [7:0] REG_RST [NREG] = '{8'h00, 8'h7F, 8'h56, 8'h0F, 8'h00,
                                           8'h00, 8'h20, 8'h0B, 8'h00};
  // writable bits, the rest read as zero
  localparam logic [7:0] REG_MASK [NREG] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                            8'h1F, 8'h3F, 8'hFF, 8'hFE};
  localparam logic [1:0] ST_IDLE  = 2'b00;
  localparam logic [1:0] ST_SYNTH = 2'b01;
  localparam logic [1:0] ST_TX    = 2'b10;
  localparam logic [1:0] ST_RX    = 2'b11;
  localparam logic [2:0] TERM_OFF = 3'b000;
  localparam logic [2:0] TERM_CS  = 3'b001;
  localparam logic [2:0] DIV_CS1  = 3'b010;
  localparam logic [2:0] DIV_CSN  = 3'b011;
  localparam logic [2:0] TERM_PQ  = 3'b100;
  localparam logic [2:0] DIV_PQ1  = 3'b101;
  localparam logic [2:0] DIV_PQN  = 3'b110;
  localparam logic [1:0] TOC_WIDE = 2'b11;
  localparam logic [5:0] AMP_LIN_MIN = 6'h03;
  localparam logic [3:0] HALF_16THS  = 4'h8;
  localparam logic [8:0] LEN_MAX     = 9'h100;

  typedef enum logic [4:0] {
    RRTC_IDLE  = 5'b00001,
    RRTC_SLEEP = 5'b00010,
    RRTC_SYNTH = 5'b00100,
    RRTC_TX    = 5'b01000,
    RRTC_RX    = 5'b10000
  } rrtc_state_t;

  typedef struct packed {
    logic       unused;
    logic       cal_wake;
    logic [1:0] after_tx_state_sel;
    logic       bad_packet_abort_en;
    logic [2:0] rx_term_antenna_sel;
  } rrtc_end_t;
  typedef struct packed {
    logic       spare;
    logic       amp_ramp_shape_en;
    logic [5:0] amp_target_level;
  } rrtc_ramp_t;
  typedef struct packed {
    logic [2:0] first_step_level;
    logic [2:0] second_step_level;
    logic [1:0] ramp_length_sel;
  } rrtc_shape_t;
  typedef struct packed {
    logic [1:0] amplitude_filter_bw;
    logic [5:0] amplitude_depth;
  } rrtc_ask_t;
  typedef struct packed {
    logic [2:0] unused;
    logic [2:0] mixer_if_sel;
    logic [1:0] spare;
  } rrtc_mix_t;
  typedef struct packed {
    logic [1:0] unused;
    logic       freq_corr_en;
    logic [1:0] freq_corr_cfg;
    logic       freq_corr_limit;
    logic [1:0] freq_corr_gain;
  } rrtc_foc_t;
  typedef struct packed {
    logic [1:0] timing_corr_limit;
    logic [2:0] timing_presync_window;
    logic [2:0] timing_postsync_window;
  } rrtc_toc_t;
  typedef struct packed {
    logic [1:0] after_rx_state_sel;
    logic       carrier_gate;
    logic       rx_limit_cfg;
    logic       raw_stream_en;
    logic       fixed_len_mode;
    logic       wor_used;
    logic       unused;
  } rrtc_misc_t;

  typedef struct packed {
    logic [5:0] amp_low_level;
    logic       keyed_off;
    logic       amp_special;
    logic       ramp_en;
    logic [3:0] first_step_16ths;
    logic [3:0] second_step_16ths;
    logic [5:0] ramp_8ths;
    logic [3:0] shape_32nds;
    logic [4:0] ask_scale_pct;
    logic [3:0] ask_mult;
    logic [8:0] frame_bytes;
    logic       frame_is_max;
    logic       if_zero;
    logic       if_positive;
    logic [3:0] if_div;
    logic       foc_active;
    logic       foc_in_synth;
    logic [3:0] foc_synth_shift;
    logic [3:0] freq_corr_limit_div;
    logic       foc_stop_after_sync;
    logic [3:0] foc_track_shift;
    logic       toc_block_mode;
    logic [8:0] toc_window_syms;
    logic [3:0] toc_prop_16ths;
    logic       timing_offset_correction_config_err;
  } rrtc_cfg_t;
endpackage
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the radio end and correction register bank
`default_nettype none
module testbench import rrtc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock, i_reset, i_clk_en, psel, penable, pwrite, ok_cs, ok_pq;
  logic        pready, pslverr, antenna, term, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, d32;
  logic [8:0]  ev, m;
  logic [5:0]  t, d;
  logic [3:0]  a;
  rrtc_state_t state;
  rrtc_cfg_t   cfg;
  int          n_fail, tests_run;
  logic [7:0]  rst_v [9] = '{8'h00, 8'h7F, 8'h56, 8'h0F, 8'h00, 8'h00, 8'h20, 8'h0B, 8'h00};
  logic [7:0]  msk_v [9] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h3F, 8'hFF, 8'hFE};
  int          rl [4] = '{3, 12, 24, 48};
  int          sc [4] = '{28, 18, 15, 14};

  rrtc_bank u_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_tx_start(ev[0]), .i_rx_start(ev[1]), .i_tx_done(ev[2]), .i_rx_good(ev[3]),
    .i_rx_bad(ev[4]), .i_rx_timeout(ev[5]), .i_sync_det(ev[6]), .i_cs_eval(ev[7]),
    .i_cs_ok(ok_cs), .i_pq_eval(ev[8]), .i_pq_ok(ok_pq), .o_radio_state(state),
    .o_antenna(antenna), .o_rx_terminated(term), .o_cfg(cfg)
  );

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  function automatic logic [7:0] ad(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  function automatic rrtc_state_t st(input logic [1:0] s);
    case (s)
      2'b00: return RRTC_IDLE;
      2'b01: return RRTC_SYNTH;
      2'b10: return RRTC_TX;
      default: return RRTC_RX;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] ad_i, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad_i;
    pwdata <= dat;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) check(32'h0, 32'h1, "no pready");
  endtask

  task automatic pulse(input logic [8:0] mk);
    @(posedge i_clock);
    ev <= mk;
    @(posedge i_clock);
    ev <= '0;
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  task automatic rst_dut;
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // generous bound, the sequence needs well under a tenth of it
  initial begin
    repeat (40000) @(posedge i_clock);
    n_fail++;
    conclude;
  end

  initial begin
    i_reset = 1'b1;
    i_clk_en = 1'b1;
    {psel, penable, pwrite, ok_cs, ok_pq} = '0;
    paddr = '0;
    pwdata = '0;
    ev = '0;
    void'($urandom(32'h0000_e02d));
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ad(4'(i)), 32'h0);
      check(rd, {24'h0, rst_v[i]}, "reset value");
    end
    for (int i = 0; i < 40; i++) begin
      a = 4'($urandom_range(0, 8));
      d32 = $urandom;
      apb(1'b1, ad(a), d32);
      apb(1'b0, ad(a), 32'h0);
      check(rd, {24'h0, d32[7:0] & msk_v[a]}, "readback");
    end
    apb(1'b1, 8'h28, 32'h0);
    check(32'(er), 32'h1, "unmapped error");
    apb(1'b0, 8'h02, 32'h0);
    check({rd[30:0], er}, 32'h1, "unaligned error");
    $display("registers done");
    apb(1'b1, ad(IX_MISC), 32'h0);
    // the upsampler setting each shape length needs is kept outside this bank
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ad(IX_SHP), {24'h0, 3'(c), 3'(c), 2'(c)});
      apb(1'b1, ad(IX_MIX), {24'h0, 3'h0, 3'(c), 2'h0});
      apb(1'b1, ad(IX_ASK), {24'h0, 2'(c), 6'h0});
      settle;
      check(32'(cfg.first_step_16ths), 32'(c), "step one");
      check(32'(cfg.second_step_16ths), 32'(8 + c), "step two");
      check(32'(cfg.ramp_8ths), 32'(rl[c % 4]), "ramp time");
      check(32'(cfg.shape_32nds), 32'(1 << (c % 4)), "shape");
      check(32'(cfg.if_zero), 32'(c % 4 == 0), "zero if");
      check(32'(cfg.if_positive), 32'(c >= 4), "if sign");
      check(32'(cfg.if_div), (c % 4 == 0) ? 32'h0 : 32'(2 + 2 * (c % 4)), "if div");
      check(32'(cfg.ask_scale_pct), 32'(sc[c % 4]), "ask scale");
      check(32'(cfg.ask_mult), 32'h4, "ask mult");
    end
    for (int i = 0; i < 12; i++) begin
      t = (i < 4) ? 6'(i) : 6'($urandom_range(3, 63));
      d = (i % 2 == 1) ? t : 6'($urandom_range(0, int'(t)));
      apb(1'b1, ad(IX_RAMP), {24'h0, 1'b0, 1'(i % 2), t});
      apb(1'b1, ad(IX_ASK), {24'h0, 2'h0, d});
      apb(1'b1, ad(IX_LEN), {24'h0, 2'(i), t});
      settle;
      check(32'(cfg.amp_low_level), 32'(t - d), "low level");
      check(32'(cfg.keyed_off), 32'(t == d), "keyed off");
      check(32'(cfg.amp_special), 32'(t < 3), "special");
      check(32'(cfg.ramp_en), 32'(i % 2), "ramp en");
      check(32'(cfg.frame_bytes), ({2'(i), t} == 0) ? 32'h100 : 32'({2'(i), t}), "len");
    end
    for (int i = 0; i < 24; i++) begin
      apb(1'b1, ad(IX_TOC), {24'h0, 2'(i / 6), 3'(i % 6), 3'h0});
      settle;
      if (i < 6) check(32'(cfg.toc_window_syms), 32'(8 << i), "window");
      else if (i % 6 < 2) check(32'(cfg.toc_prop_16ths), (i % 6 == 1) ? 32'h6 : 32'h8, "prop");
      check(32'(cfg.timing_offset_correction_config_err), 32'(i >= 12), "toc err");
    end
    apb(1'b1, ad(IX_MISC), 32'h30);
    settle;
    check(32'(cfg.timing_offset_correction_config_err), 32'h0, "gate set");
    check(32'(cfg.ask_mult), 32'h8, "ask mult");
    apb(1'b1, ad(IX_MISC), 32'h0);
    for (int i = 0; i < 36; i++) begin
      if (i == 32) apb(1'b1, ad(IX_MISC), 32'h8);
      apb(1'b1, ad(IX_FOC), {24'h0, 3'b001, 5'(i)});
      settle;
      if (i >= 32) check(32'(cfg.foc_track_shift), 32'(7 + i % 4), "raw gain");
      else begin
        check(32'(cfg.foc_in_synth), 32'(i >= 8), "foc place");
        if (i >= 8) check(32'(cfg.foc_synth_shift), 32'(6 + i / 8), "foc gain");
        if (i >= 8) check(32'(cfg.freq_corr_limit_div), (i % 8 >= 4) ? 32'h8 : 32'h4, "foc lim");
        check(32'(cfg.foc_stop_after_sync), 32'(i % 4 == 0), "foc stop");
        if (i % 4 != 0) check(32'(cfg.foc_track_shift), 32'(4 + i % 4), "foc track");
      end
    end
    $display("decode done");
    for (int s = 0; s < 4; s++) begin
      rst_dut;
      apb(1'b1, ad(IX_END), {26'h0, 2'(s), 4'h0});
      pulse(9'h001);
      check(32'(state), 32'(RRTC_TX), "tx start");
      pulse(9'h004);
      check(32'(state), 32'(st(2'(s))), "after tx");
      rst_dut;
      apb(1'b1, ad(IX_MISC), {24'h0, 2'(s), 6'h0});
      pulse(9'h002);
      pulse(9'h008);
      check(32'(state), 32'(st(2'(s))), "after rx");
    end
    for (int k = 0; k < 4; k++) begin
      rst_dut;
      apb(1'b1, ad(IX_END), {28'h0, 1'(k / 2), 3'h0});
      apb(1'b1, ad(IX_MISC), {24'h0, 2'b01, 4'h0, 1'(k % 2), 1'b0});
      pulse(9'h002);
      pulse(9'h010);
      if (k < 2) check(32'(state), 32'(RRTC_RX), "bad stay");
      else check(32'(state), 32'((k % 2) ? RRTC_SLEEP : RRTC_IDLE), "bad abort");
    end
    $display("states done");
    // carrier gate stays low after each reset, as preamble codes need
    for (int c = 0; c < 7; c++) begin
      rst_dut;
      apb(1'b1, ad(IX_END), {29'h0, 3'(c)});
      ok_cs <= 1'b0;
      ok_pq <= 1'b0;
      m = (c >= 4) ? 9'h100 : 9'h080;
      pulse(9'h002);
      pulse(m);
      check(32'(state), (c == 1 || c == 4) ? 32'(RRTC_IDLE) : 32'(RRTC_RX), "fail one");
      check(32'(term), 32'(c == 1 || c == 4), "term one");
      check(32'(antenna), 32'(c != 0 && c != 1 && c != 4), "switch");
      if (c == 2 || c == 5) begin
        pulse(m);
        check({28'h0, 3'(state == RRTC_IDLE), term}, 32'h3, "fail two");
      end
      if (c == 3 || c == 6) begin
        ok_cs <= 1'b1;
        ok_pq <= 1'b1;
        pulse(m);
        check({28'h0, 3'(state == RRTC_RX), antenna}, 32'h3, "found");
        pulse(9'h020);
        check({28'h0, 3'(state == RRTC_IDLE), term}, 32'h3, "timeout");
      end
    end
    $display("termination done");
    // a low clock enable must swallow a start strobe
    rst_dut;
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    pulse(9'h001);
    check(32'(state), 32'(RRTC_IDLE), "frozen");
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    $display("enable done");
    conclude;
  end
endmodule // testbench
`default_nettype wire
